// ---- rtl/interval_timer_control_regs.v ----
// control registers and interrupt mask logic for two interval timers
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctrl_map.vh"

module interval_timer_control_regs
#(
    parameter FLAG_COUNT = 5
)
(
    input  wire                  ref_clk,
    input  wire                  rst,
    input  wire                  cs_n,
    input  wire                  rw,
    input  wire [3:0]            rs,
    input  wire [7:0]            db_in,
    output wire [7:0]            db_out,
    output wire                  db_oe,
    input  wire [FLAG_COUNT-1:0] int_flags,
    output wire                  summary_request_flag,
    output wire                  irq_n,
    input  wire                  counter_pin_in,
    input  wire                  shift_clock,
    output wire                  counter_pin_out,
    output wire                  counter_pin_oe,
    input  wire                  timer_a_underflow,
    input  wire                  timer_b_underflow,
    output wire                  timer_a_count_en,
    output wire                  timer_b_count_en,
    output wire                  timer_a_force_load,
    output wire                  timer_b_force_load,
    output wire                  timer_a_running,
    output wire                  timer_b_running,
    output wire                  port_b_line_six_out,
    output wire                  port_b_line_six_oe,
    output wire                  port_b_line_seven_out,
    output wire                  port_b_line_seven_oe,
    output wire                  serial_direction_select,
    output wire                  tod_frequency_select,
    output wire                  tod_write_to_alarm
);

    // address decode shared by read and write paths
    function hit;
        input [3:0] sel;
        input [3:0] ofs;
        begin
            hit = (sel == ofs);
        end
    endfunction

    reg  [7:0]            ctrl_a_q;
    reg  [7:0]            ctrl_b_q;
    reg  [FLAG_COUNT-1:0] mask_q;
    reg                   req_q;
    reg                   load_a_q;
    reg                   load_b_q;
    reg                   pin_last_q;
    reg  [7:0]            rdata_q;
    reg                   rd_oe_q;
    reg  [7:0]            rdata_d;

    wire                  wr_en;
    wire                  rd_en;
    wire                  wr_a;
    wire                  wr_b;
    wire                  wr_mask;
    wire                  pin_rise;
    wire [1:0]            src_b;
    wire                  run_a;
    wire                  run_b;

    ////////////////////////////////////////////////////////////////////////
    // bus access: every clock with chip select low is one access
    assign wr_en   = !cs_n && !rw;
    assign rd_en   = !cs_n && rw;
    assign wr_a    = wr_en && hit(rs, `OFS_TIMER_A_CONTROL);
    assign wr_b    = wr_en && hit(rs, `OFS_TIMER_B_CONTROL);
    assign wr_mask = wr_en && hit(rs, `OFS_INT_MASK);

    ////////////////////////////////////////////////////////////////////////
    // stored control bits; bit 0 lives in the output units
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            ctrl_a_q <= `RST_CONTROL;
            ctrl_b_q <= `RST_CONTROL;
        end
        else
        begin
            // strobe and start positions never stored here
            if (wr_a)
                ctrl_a_q <= db_in & 8'hEE;
            if (wr_b)
                ctrl_b_q <= db_in & 8'hEE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // force load strobes, one clock wide, no storage
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            load_a_q <= 1'b0;
            load_b_q <= 1'b0;
        end
        else
        begin
            load_a_q <= wr_a && db_in[`BIT_FORCE_LOAD];
            load_b_q <= wr_b && db_in[`BIT_FORCE_LOAD];
        end
    end

    assign timer_a_force_load = load_a_q;
    assign timer_b_force_load = load_b_q;

    ////////////////////////////////////////////////////////////////////////
    // interrupt mask with set/clear write semantics
    always @(posedge ref_clk)
    begin
        if (rst)
            mask_q <= `RST_MASK;
        else if (wr_mask)
        begin
            if (db_in[`BIT_MASK_SET_CLEAR])
                mask_q <= mask_q | db_in[FLAG_COUNT-1:0];
            else
                mask_q <= mask_q & ~db_in[FLAG_COUNT-1:0];
        end
    end

    // summary request only from masked-in flags, one clock behind
    always @(posedge ref_clk)
    begin
        if (rst)
            req_q <= 1'b0;
        else
            req_q <= |(int_flags & mask_q);
    end

    assign summary_request_flag = req_q;
    assign irq_n                = ~req_q;

    ////////////////////////////////////////////////////////////////////////
    // counter pin rise detect; pin is already synchronous to ref_clk;
    // resets to the idle high level so release gives no false rise
    always @(posedge ref_clk)
    begin
        if (rst)
            pin_last_q <= 1'b1;
        else
            pin_last_q <= counter_pin_in;
    end

    assign pin_rise = counter_pin_in && !pin_last_q;
    assign src_b    = {ctrl_b_q[`BIT_SRC_B_HIGH], ctrl_b_q[`BIT_SRC_B_LOW]};

    assign timer_a_count_en = run_a &&
                              (ctrl_a_q[`BIT_SRC_A] ? pin_rise : 1'b1);

    reg src_b_en;
    always @*
    begin
        src_b_en = 1'b0;
        case (src_b)
            `SRC_B_PHI2:     src_b_en = 1'b1;
            `SRC_B_PIN:      src_b_en = pin_rise;
            `SRC_B_TA:       src_b_en = timer_a_underflow;
            `SRC_B_TA_GATED: src_b_en = timer_a_underflow && counter_pin_in;
            default:         src_b_en = 1'b0;
        endcase
    end

    assign timer_b_count_en = run_b && src_b_en;

    ////////////////////////////////////////////////////////////////////////
    // serial direction and shift clock on the counter pin
    assign serial_direction_select = ctrl_a_q[`BIT_SERIAL_DIR];
    assign counter_pin_oe          = ctrl_a_q[`BIT_SERIAL_DIR];
    assign counter_pin_out         = shift_clock;
    assign tod_frequency_select    = ctrl_a_q[`BIT_TOD_FREQ];
    assign tod_write_to_alarm      = ctrl_b_q[`BIT_ALARM_SEL];

    ////////////////////////////////////////////////////////////////////////
    // per-timer start bit and port line logic
    // timer a drives port b line six
    timer_output_unit u_out_a
    (
        .ref_clk                (ref_clk),
        .rst                    (rst),
        .ctrl_wr                (wr_a),
        .wr_start               (db_in[`BIT_START]),
        .one_shot_select        (ctrl_a_q[`BIT_ONE_SHOT]),
        .toggle_or_pulse_select (ctrl_a_q[`BIT_TOGGLE_SEL]),
        .port_output_enable     (ctrl_a_q[`BIT_PORT_OUT_EN]),
        .underflow              (timer_a_underflow),
        .running                (run_a),
        .port_line_out          (port_b_line_six_out),
        .port_line_oe           (port_b_line_six_oe)
    );

    // timer b drives port b line seven
    timer_output_unit u_out_b
    (
        .ref_clk                (ref_clk),
        .rst                    (rst),
        .ctrl_wr                (wr_b),
        .wr_start               (db_in[`BIT_START]),
        .one_shot_select        (ctrl_b_q[`BIT_ONE_SHOT]),
        .toggle_or_pulse_select (ctrl_b_q[`BIT_TOGGLE_SEL]),
        .port_output_enable     (ctrl_b_q[`BIT_PORT_OUT_EN]),
        .underflow              (timer_b_underflow),
        .running                (run_b),
        .port_line_out          (port_b_line_seven_out),
        .port_line_oe           (port_b_line_seven_oe)
    );

    assign timer_a_running = run_a;
    assign timer_b_running = run_b;

    ////////////////////////////////////////////////////////////////////////
    // read mux; mask is write-only so its offset shows flag state instead
    always @*
    begin
        rdata_d = `RST_DATA;
        if (hit(rs, `OFS_TIMER_A_CONTROL))
            rdata_d = {ctrl_a_q[7:1], run_a};
        else if (hit(rs, `OFS_TIMER_B_CONTROL))
            rdata_d = {ctrl_b_q[7:1], run_b};
        else if (hit(rs, `OFS_INT_MASK))
            rdata_d = {req_q, {(7-FLAG_COUNT){1'b0}}, int_flags};
    end

    // read data registered; unmapped offsets read zero
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            rdata_q <= `RST_DATA;
            rd_oe_q <= 1'b0;
        end
        else
        begin
            rd_oe_q <= rd_en;
            rdata_q <= rd_en ? rdata_d : `RST_DATA;
        end
    end

    assign db_out = rdata_q;
    assign db_oe  = rd_oe_q;

endmodule // interval_timer_control_regs
`default_nettype wire

// ---- rtl/timer_ctrl_map.vh ----
// register offsets, field positions and reset values of the timer control block
`ifndef TIMER_CTRL_MAP_VH
`define TIMER_CTRL_MAP_VH

// register select offsets
`define OFS_INT_MASK        4'hD
`define OFS_TIMER_A_CONTROL 4'hE
`define OFS_TIMER_B_CONTROL 4'hF

// control register field positions
`define BIT_START           0
`define BIT_PORT_OUT_EN     1
`define BIT_TOGGLE_SEL      2
`define BIT_ONE_SHOT        3
`define BIT_FORCE_LOAD      4
`define BIT_SRC_A           5
`define BIT_SRC_B_LOW       5
`define BIT_SRC_B_HIGH      6
`define BIT_SERIAL_DIR      6
`define BIT_TOD_FREQ        7
`define BIT_ALARM_SEL       7
`define BIT_MASK_SET_CLEAR  7

// timer b count source codes
`define SRC_B_PHI2          2'h0
`define SRC_B_PIN           2'h1
`define SRC_B_TA            2'h2
`define SRC_B_TA_GATED      2'h3

// reset values
`define RST_CONTROL         8'h00
`define RST_MASK            5'h00
`define RST_DATA            8'h00

`endif

// ---- rtl/timer_output_unit.v ----
// start bit, one-shot stop and port line output of one interval timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctrl_map.vh"

module timer_output_unit
(
    input  wire ref_clk,
    input  wire rst,
    input  wire ctrl_wr,
    input  wire wr_start,
    input  wire one_shot_select,
    input  wire toggle_or_pulse_select,
    input  wire port_output_enable,
    input  wire underflow,
    output wire running,
    output wire port_line_out,
    output wire port_line_oe
);

    reg  start_q;
    reg  toggle_q;
    reg  pulse_q;

    ////////////////////////////////////////////////////////////////////////
    // start bit: a software write wins over the one-shot self clear,
    // so a restart written in the underflow cycle is never lost
    always @(posedge ref_clk)
    begin
        if (rst)
            start_q <= 1'b0;
        else if (ctrl_wr)
            start_q <= wr_start;
        else if (underflow && one_shot_select)
            start_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // toggle and pulse outputs
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            toggle_q <= 1'b0;
            pulse_q  <= 1'b0;
        end
        else
        begin
            pulse_q <= underflow;       // one clock wide per underflow
            if (ctrl_wr && wr_start && !start_q)
                toggle_q <= 1'b1;       // forced high on start
            else if (underflow)
                toggle_q <= ~toggle_q;
        end
    end

    // port line drive and output mode
    assign port_line_out = toggle_or_pulse_select ? toggle_q : pulse_q;
    assign port_line_oe  = port_output_enable;
    assign running       = start_q;

endmodule // timer_output_unit
`default_nettype wire

// ---- verif/timer_ctrl_properties.sv ----
// port assertions for the timer control register block
`timescale 1ns/1ps
`default_nettype none
module timer_ctrl_checker
#(
    parameter FLAG_COUNT = 5
)
(
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire logic                  cs_n,
    input wire logic                  rw,
    input wire logic [3:0]            rs,
    input wire logic [7:0]            db_in,
    input wire logic [7:0]            db_out,
    input wire logic                  db_oe,
    input wire logic [FLAG_COUNT-1:0] int_flags,
    input wire logic                  summary_request_flag,
    input wire logic                  counter_pin_in,
    input wire logic                  counter_pin_oe,
    input wire logic                  timer_a_underflow,
    input wire logic                  timer_a_count_en,
    input wire logic                  timer_b_count_en,
    input wire logic                  timer_a_force_load,
    input wire logic                  timer_a_running,
    input wire logic                  timer_b_running,
    input wire logic                  port_b_line_six_out,
    input wire logic                  port_b_line_six_oe,
    input wire logic                  tod_frequency_select
);
logic [7:0]            cta_q;
logic [7:0]            ctb_q;
logic [FLAG_COUNT-1:0] mask_q;
logic                  wr_a;
logic                  wr_b;
logic                  wr_m;
logic                  rd_a;
// decode of host accesses
assign wr_a = !cs_n && !rw && rs == 4'hE;
assign wr_b = !cs_n && !rw && rs == 4'hF;
assign wr_m = !cs_n && !rw && rs == 4'hD;
assign rd_a = !cs_n && rw && rs == 4'hE;
// shadow of written state; the run bit is shadowed too but never checked, since it self clears
always @(posedge ref_clk)
begin
    if (rst)
    begin
        cta_q  <= 8'h00;
        ctb_q  <= 8'h00;
        mask_q <= '0;
    end
    else
    begin
        if (wr_a)
            cta_q <= db_in;
        if (wr_b)
            ctb_q <= db_in;
        if (wr_m)
            mask_q <= db_in[7] ? (mask_q | db_in[FLAG_COUNT-1:0])
                               : (mask_q & ~db_in[FLAG_COUNT-1:0]);
    end
end
////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge ref_clk); endclocking
default disable iff (rst);
property p_summary;
    summary_request_flag == $past(|(int_flags & mask_q));
endproperty
a_summary: assert property (p_summary)
    else $error("summary flag disagrees with masked flags");
property p_force_a;
    timer_a_force_load == $past(wr_a && db_in[4]);
endproperty
a_force_a: assert property (p_force_a)
    else $error("force load pulse wrong");
property p_read_a;
    rd_a |=> db_oe && db_out[7:1] == ($past(cta_q[7:1]) & 7'h77);
endproperty
a_read_a: assert property (p_read_a)
    else $error("control read back wrong");
property p_one_shot;
    timer_a_running && cta_q[3] && timer_a_underflow && !wr_a
        |=> !timer_a_running;
endproperty
a_one_shot: assert property (p_one_shot)
    else $error("one shot did not stop");
property p_continuous;
    timer_a_running && !cta_q[3] && !wr_a |=> timer_a_running;
endproperty
a_continuous: assert property (p_continuous)
    else $error("continuous timer stopped");
property p_pulse;
    !cta_q[2] && !wr_a |=> port_b_line_six_out == $past(timer_a_underflow);
endproperty
a_pulse: assert property (p_pulse)
    else $error("pulse output wrong");
property p_toggle;
    cta_q[2] && timer_a_underflow && timer_a_running && !wr_a
        |=> port_b_line_six_out != $past(port_b_line_six_out);
endproperty
a_toggle: assert property (p_toggle)
    else $error("toggle output did not invert");
property p_pins;
    {port_b_line_six_oe, counter_pin_oe, tod_frequency_select}
        == {cta_q[1], cta_q[6], cta_q[7]};
endproperty
a_pins: assert property (p_pins)
    else $error("pin selects disagree with control");
property p_src_b;
    ctb_q[6] |-> timer_b_count_en == (timer_b_running && timer_a_underflow
        && (!ctb_q[5] || counter_pin_in));
endproperty
a_src_b: assert property (p_src_b)
    else $error("timer b chained source wrong");
property p_src_a;
    !cta_q[5] |-> timer_a_count_en == timer_a_running;
endproperty
a_src_a: assert property (p_src_a)
    else $error("timer a clock source wrong");
c_one_shot: cover property (timer_a_running && cta_q[3] && timer_a_underflow);
c_mask_set: cover property (wr_m && db_in[7]);
c_gated: cover property (ctb_q[6:5] == 2'h3 && timer_b_count_en);
endmodule // timer_ctrl_checker
bind interval_timer_control_regs timer_ctrl_checker
    #(.FLAG_COUNT(FLAG_COUNT)) u_chk (.*);
`default_nettype wire

// ---- verif/host_bus_model.sv ----
// host processor model driving the register bus
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] db_out,
    input  wire logic       db_oe,
    output var  logic       cs_n,
    output var  logic       rw,
    output var  logic [3:0] rs,
    output var  logic [7:0] db_in
);
initial
begin
    cs_n = 1'b1;
    rw = 1'b1;
    rs = 4'h0;
    db_in = 8'h00;
end
// set up on a falling edge, held over the taking edge, released after;
// idle data is inverted so a stale byte cannot pass for a fresh one
task automatic access(input logic r, input logic [3:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(negedge ref_clk);
    cs_n = 1'b0;
    rw = r;
    rs = a;
    db_in = r ? ~db_in : d;
    @(negedge ref_clk);
    q = (db_oe === 1'b1) ? db_out : 8'hXX;
    cs_n = 1'b1;
    rw = 1'b1;
    db_in = ~db_in;
endtask
endmodule // host_bus_model
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench for the timer control registers
`timescale 1ns/1ps
`default_nettype none
module tb;
logic ref_clk = 1'b0, rst = 1'b1, counter_pin_in = 1'b1, shift_clock = 1'b0;
logic timer_a_underflow = 1'b0, timer_b_underflow = 1'b0;
logic [4:0] int_flags = 5'h00;
logic cs_n, rw, db_oe, summary_request_flag, irq_n, counter_pin_out;
logic [3:0] rs;
logic [7:0] db_in, db_out, q;
logic counter_pin_oe, timer_a_count_en, timer_b_count_en, timer_a_force_load;
logic timer_b_force_load, timer_a_running, timer_b_running;
logic port_b_line_six_out, port_b_line_six_oe, port_b_line_seven_out;
logic port_b_line_seven_oe, serial_direction_select, tod_frequency_select;
logic tod_write_to_alarm;
int n_errors = 0;
int total_checks = 0;
always #20 ref_clk = ~ref_clk;
interval_timer_control_regs #(.FLAG_COUNT(5)) DUT (.*);
host_bus_model host (.*);
////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
        n_errors++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host.access(1'b0, a, d, q);
endtask
task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    host.access(1'b1, a, 8'h00, q);
    chk(q, e);
endtask
task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
// the tests need about 70 cycles; 3000 means a hang
initial
begin
    #(40 * 3000);
    n_errors++;
    print_verdict;
end
////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    rd_chk(4'hE, 8'h00);
    rd_chk(4'hF, 8'h00);
    rd_chk(4'hD, 8'h00);
    $display("test reset done");
    int_flags = 5'h1F;
    wr(4'hD, 8'h85);
    rd_chk(4'hD, 8'h9F);
    wr(4'hD, 8'h01);
    int_flags = 5'h01;
    rd_chk(4'hD, 8'h01);
    wr(4'hD, 8'h80);
    int_flags = 5'h04;
    rd_chk(4'hD, 8'h84);
    chk({7'h00, irq_n}, 8'h00);
    wr(4'hD, 8'h04);
    rd_chk(4'hD, 8'h04);
    chk({7'h00, irq_n}, 8'h01);
    $display("test mask done");
    wr(4'hE, 8'hFF);
    chk({serial_direction_select, tod_frequency_select, port_b_line_six_oe,
         counter_pin_oe, timer_a_running, timer_a_force_load, 2'h0},
        8'hFC);
    rd_chk(4'hE, 8'hEF);
    wr(4'hE, 8'h0B);
    timer_a_underflow = 1'b1;
    @(negedge ref_clk);
    timer_a_underflow = 1'b0;
    chk({5'h00, timer_a_running, port_b_line_six_out, port_b_line_six_oe},
        8'h03);
    @(negedge ref_clk);
    chk({7'h00, port_b_line_six_out}, 8'h00);
    rd_chk(4'hE, 8'h0A);
    wr(4'hF, 8'h97);
    chk({timer_b_running, port_b_line_seven_out, port_b_line_seven_oe,
         tod_write_to_alarm, timer_b_force_load, 3'h0}, 8'hF8);
    timer_b_underflow = 1'b1;
    @(negedge ref_clk);
    timer_b_underflow = 1'b0;
    chk({6'h00, timer_b_running, port_b_line_seven_out}, 8'h02);
    rd_chk(4'hF, 8'h87);
    $display("test timers done");
    for (int c = 0; c < 4; c++)
    begin
        wr(4'hF, {1'b0, c[1:0], 5'h01});
        timer_a_underflow = c[0];
        counter_pin_in = 1'b0;
        @(negedge ref_clk);
        counter_pin_in = 1'b1;
        #1;
        chk({7'h00, timer_b_count_en}, {7'h00, c != 2});
    end
    timer_a_underflow = 1'b0;
    // timer a counting pin rises, shift clock passed to the pin
    wr(4'hE, 8'h21);
    counter_pin_in = 1'b0;
    shift_clock = 1'b1;
    @(negedge ref_clk);
    counter_pin_in = 1'b1;
    #1;
    chk({6'h00, counter_pin_out, timer_a_count_en}, 8'h03);
    @(negedge ref_clk);
    chk({7'h00, timer_a_count_en}, 8'h00);
    shift_clock = 1'b0;
    #1;
    chk({7'h00, counter_pin_out}, 8'h00);
    $display("test sources done");
    print_verdict;
end
endmodule // tb
`default_nettype wire
